// ===== pkg/sdsm_pkg.sv
// constants for the servo drive status monitor register bank
package sdsm_pkg;
  localparam int WORD_W = 16;
  localparam int IDX_W = 10;
  // parameter numbers of the monitor words
  localparam logic [9:0] IDX_EVENT_ACTION = 10'h004;
  localparam logic [9:0] IDX_DRIVE_PROT = 10'h005;
  localparam logic [9:0] IDX_SYSTEM_PROT = 10'h006;
  localparam logic [9:0] IDX_STATUS_ONE = 10'h007;
  localparam logic [9:0] IDX_STATUS_TWO = 10'h008;
  localparam logic [9:0] IDX_STATUS_THREE = 10'h009;
  localparam logic [9:0] IDX_ACTIVE_CFG = 10'h00a;
  localparam logic [9:0] IDX_STATE_WORD = 10'h390;
  // implemented-bit masks, reserved bits read zero
  localparam logic [15:0] MASK_EVENT_ACTION = 16'h00ff;
  localparam logic [15:0] MASK_DRIVE_PROT = 16'h007f;
  localparam logic [15:0] MASK_SYSTEM_PROT = 16'h3fff;
  localparam logic [15:0] MASK_STATUS_ONE = 16'hffff;
  localparam logic [15:0] MASK_STATUS_TWO = 16'hf7ff;
  localparam logic [15:0] MASK_STATUS_THREE = 16'h1fff;
  localparam logic [15:0] MASK_ACTIVE_CFG = 16'h0007;
  localparam logic [15:0] MASK_STATE_WORD = 16'h006f;
  localparam logic [15:0] WORD_ZERO = 16'h0000;
  // state word low nibble codes
  localparam logic [3:0] LOW_IDLE = 4'h0;
  localparam logic [3:0] LOW_READY = 4'h1;
  localparam logic [3:0] LOW_ON = 4'h3;
  localparam logic [3:0] LOW_ENABLED = 4'h7;
  localparam logic [3:0] LOW_FAULT = 4'h8;
  localparam logic [3:0] LOW_REACT = 4'hf;
  localparam int BIT_QUICK = 5;
  localparam int BIT_DISABLED = 6;
  // drive control states, one-hot
  typedef enum logic [7:0] {
    ST_NOT_READY = 8'b0000_0001,
    ST_ON_DISABLED = 8'b0000_0010,
    ST_READY = 8'b0000_0100,
    ST_SWITCHED_ON = 8'b0000_1000,
    ST_ENABLED = 8'b0001_0000,
    ST_STOP = 8'b0010_0000,
    ST_REACTION = 8'b0100_0000,
    ST_FAULT = 8'b1000_0000
  } sdsm_state_t;
endpackage

// ===== src/sdsm_monitor.sv
// servo drive status monitor: state word and status flag words, read only
// Notes on behaviour
// - state word: 16-bit read-only, identifies drive state
// - not ready: low nibble 0000, bit6 clear
// - switch-on disabled: low nibble 0000, bit6 set
// - ready to switch on: 0001, bit5 set
// - switched on: 0011, bit5 set, bit6 clear
// - enabled 0111 bit5 set; stop bit5 clear
// - fault reaction: low nibble 1111, bit6 clear
// - fault: low nibble 1000, bit6 clear
// - status words: 16-bit read-only independent flags
// - bridge word flags bits 0..7
// - drive protection word flags bits 0..6
// - system protection word flags bits 0..13
`timescale 1ns/1ps
`default_nettype none
module sdsm_monitor #(
  parameter int WORD_W = 16
) (
  input wire logic mclk,
  input wire logic rst_n,
  // present drive state from the control machine, same clock
  input wire sdsm_pkg::sdsm_state_t driveState,
  // raw condition flags from the drive logic, same clock
  input wire logic [WORD_W-1:0] bridgeFlags,
  input wire logic [WORD_W-1:0] driveProtFlags,
  input wire logic [WORD_W-1:0] systemProtFlags,
  input wire logic [WORD_W-1:0] statusOneFlags,
  input wire logic [WORD_W-1:0] statusTwoFlags,
  input wire logic [WORD_W-1:0] statusThreeFlags,
  input wire logic [WORD_W-1:0] activeCfgFlags,
  // parameter read port: request index, answer next cycle
  input wire logic readReq,
  input wire logic [sdsm_pkg::IDX_W-1:0] readIndex,
  output logic readValid,
  output logic readHit,
  output logic [WORD_W-1:0] readData,
  // live state word, registered
  output logic [WORD_W-1:0] driveStateWord
);

  logic [WORD_W-1:0] next_stateWord;
  logic [WORD_W-1:0] eventAction;
  logic [WORD_W-1:0] driveProt;
  logic [WORD_W-1:0] systemProt;
  logic [WORD_W-1:0] statusOne;
  logic [WORD_W-1:0] statusTwo;
  logic [WORD_W-1:0] statusThree;
  logic [WORD_W-1:0] activeCfg;
  logic [3:0] lowNibble;
  logic quickBit;
  logic disabledBit;

  // state pattern encode; don't-care bits are driven zero
  always_comb begin
    lowNibble = sdsm_pkg::LOW_IDLE;
    quickBit = 1'b0;
    disabledBit = 1'b0;
    case (driveState)
      sdsm_pkg::ST_NOT_READY: begin
        lowNibble = sdsm_pkg::LOW_IDLE;
      end
      sdsm_pkg::ST_ON_DISABLED: begin
        lowNibble = sdsm_pkg::LOW_IDLE;
        disabledBit = 1'b1;
      end
      sdsm_pkg::ST_READY: begin
        lowNibble = sdsm_pkg::LOW_READY;
        quickBit = 1'b1;
      end
      sdsm_pkg::ST_SWITCHED_ON: begin
        lowNibble = sdsm_pkg::LOW_ON;
        quickBit = 1'b1;
      end
      sdsm_pkg::ST_ENABLED: begin
        lowNibble = sdsm_pkg::LOW_ENABLED;
        quickBit = 1'b1;
      end
      sdsm_pkg::ST_STOP: begin
        lowNibble = sdsm_pkg::LOW_ENABLED;
      end
      sdsm_pkg::ST_REACTION: begin
        lowNibble = sdsm_pkg::LOW_REACT;
      end
      sdsm_pkg::ST_FAULT: begin
        lowNibble = sdsm_pkg::LOW_FAULT;
      end
      default: begin
        lowNibble = sdsm_pkg::LOW_IDLE; // illegal code reads as not ready
      end
    endcase
  end

  // assemble the state word, everything above bit 6 stays zero
  always_comb begin
    next_stateWord = sdsm_pkg::WORD_ZERO;
    next_stateWord[3:0] = lowNibble;
    next_stateWord[sdsm_pkg::BIT_QUICK] = quickBit;
    next_stateWord[sdsm_pkg::BIT_DISABLED] = disabledBit;
  end

  // status words sampled every cycle so a read sees one coherent snapshot
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      driveStateWord <= sdsm_pkg::WORD_ZERO;
      eventAction <= sdsm_pkg::WORD_ZERO;
      driveProt <= sdsm_pkg::WORD_ZERO;
      systemProt <= sdsm_pkg::WORD_ZERO;
      statusOne <= sdsm_pkg::WORD_ZERO;
      statusTwo <= sdsm_pkg::WORD_ZERO;
      statusThree <= sdsm_pkg::WORD_ZERO;
      activeCfg <= sdsm_pkg::WORD_ZERO;
    end else begin
      driveStateWord <= next_stateWord;
      eventAction <= bridgeFlags & sdsm_pkg::MASK_EVENT_ACTION;
      driveProt <= driveProtFlags & sdsm_pkg::MASK_DRIVE_PROT;
      systemProt <= systemProtFlags & sdsm_pkg::MASK_SYSTEM_PROT;
      statusOne <= statusOneFlags & sdsm_pkg::MASK_STATUS_ONE;
      statusTwo <= statusTwoFlags & sdsm_pkg::MASK_STATUS_TWO;
      statusThree <= statusThreeFlags & sdsm_pkg::MASK_STATUS_THREE;
      activeCfg <= activeCfgFlags & sdsm_pkg::MASK_ACTIVE_CFG;
    end
  end

  // index decode; there is no write path at all, so writes cannot land
  wire hitEvent = readIndex == sdsm_pkg::IDX_EVENT_ACTION;
  wire hitDrive = readIndex == sdsm_pkg::IDX_DRIVE_PROT;
  wire hitSystem = readIndex == sdsm_pkg::IDX_SYSTEM_PROT;
  wire hitOne = readIndex == sdsm_pkg::IDX_STATUS_ONE;
  wire hitTwo = readIndex == sdsm_pkg::IDX_STATUS_TWO;
  wire hitThree = readIndex == sdsm_pkg::IDX_STATUS_THREE;
  wire hitCfg = readIndex == sdsm_pkg::IDX_ACTIVE_CFG;
  wire hitState = readIndex == sdsm_pkg::IDX_STATE_WORD;
  wire anyHit = hitEvent | hitDrive | hitSystem | hitOne | hitTwo | hitThree | hitCfg
    | hitState;
  // one-hot select keeps the mux flat
  wire [WORD_W-1:0] selWord = ({WORD_W{hitEvent}} & eventAction)
    | ({WORD_W{hitDrive}} & driveProt)
    | ({WORD_W{hitSystem}} & systemProt)
    | ({WORD_W{hitOne}} & statusOne)
    | ({WORD_W{hitTwo}} & statusTwo)
    | ({WORD_W{hitThree}} & statusThree)
    | ({WORD_W{hitCfg}} & activeCfg)
    | ({WORD_W{hitState}} & driveStateWord);

  // read answer one cycle after the request; unmapped index answers zero
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      readValid <= 1'b0;
      readHit <= 1'b0;
      readData <= sdsm_pkg::WORD_ZERO;
    end else begin
      readValid <= readReq;
      readHit <= readReq & anyHit;
      if (readReq) begin
        readData <= selWord;
      end
    end
  end

  // checks on the encode and read path
  stop_bit_clear_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_STOP |=> driveStateWord[6:0] == 7'h07)
    else $error("stop state pattern wrong");
  enabled_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_ENABLED |=> driveStateWord[6:0] == 7'h27)
    else $error("enabled pattern wrong");
  not_ready_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_NOT_READY |=> driveStateWord[3:0] == 4'h0
    && !driveStateWord[6])
    else $error("not ready pattern wrong");
  on_disabled_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_ON_DISABLED |=> driveStateWord[6:0] == 7'h40)
    else $error("switch on disabled pattern wrong");
  ready_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_READY |=> driveStateWord[6:0] == 7'h21)
    else $error("ready pattern wrong");
  switched_on_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_SWITCHED_ON |=> driveStateWord[6:0] == 7'h23)
    else $error("switched on pattern wrong");
  reaction_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_REACTION |=> driveStateWord[3:0] == 4'hf
    && !driveStateWord[6])
    else $error("fault reaction pattern wrong");
  fault_bits_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveState == sdsm_pkg::ST_FAULT |=> driveStateWord[3:0] == 4'h8
    && !driveStateWord[6])
    else $error("fault pattern wrong");
  state_upper_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveStateWord[15:7] == 9'h000 && !driveStateWord[4])
    else $error("state word reserved bits set");
  bridge_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_EVENT_ACTION |=> readData[15:8] == 8'h00
    && readData[7:0] == $past(bridgeFlags[7:0], 2))
    else $error("bridge word read wrong");
  prot_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_DRIVE_PROT |=> readData[15:7] == 9'h000)
    else $error("drive protection reserved bits set");
  sys_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_SYSTEM_PROT |=> readData[15:14] == 2'b00)
    else $error("system protection reserved bits set");
  three_reserved_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_THREE |=> readData[15:13] == 3'b000)
    else $error("status three reserved bits set");
  miss_zero_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && !anyHit |=> readValid && !readHit && readData == 16'h0000)
    else $error("unmapped read not zero");

  // read handshake: one answer per taken request, nothing spontaneous;
  // readData must hold between reads so a slow host can still pick it up
  valid_follows_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq |=> readValid)
    else $error("read answer missing");
  valid_single_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !readReq |=> !readValid && !readHit)
    else $error("answer without request");
  hit_mapped_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && anyHit |=> readHit)
    else $error("mapped index not flagged");
  data_held_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !readReq |=> $stable(readData))
    else $error("read data moved without a read");
  hit_needs_valid_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readHit |-> readValid)
    else $error("hit flag without answer");

  // each mapped index must be flagged as a hit; a decode slip here would
  // otherwise show up only as a zero word, which looks like all flags clear
  state_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATE_WORD |=> readHit && readValid)
    else $error("state word index not decoded");
  event_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_EVENT_ACTION |=> readHit)
    else $error("bridge index not decoded");
  drive_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_DRIVE_PROT |=> readHit)
    else $error("drive protection index not decoded");
  sys_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_SYSTEM_PROT |=> readHit)
    else $error("system protection index not decoded");
  one_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_ONE |=> readHit)
    else $error("status one index not decoded");
  two_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_TWO |=> readHit)
    else $error("status two index not decoded");
  three_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_THREE |=> readHit)
    else $error("status three index not decoded");
  cfg_hit_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_ACTIVE_CFG |=> readHit)
    else $error("configuration index not decoded");

  // word contents: flags reach readData two edges after they are presented,
  // one edge for the snapshot and one for the read register
  state_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATE_WORD |=> readData == $past(driveStateWord))
    else $error("state word read wrong");
  drive_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_DRIVE_PROT |=> readData[6:0] == $past(driveProtFlags[6:0], 2))
    else $error("drive protection flags lost");
  sys_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_SYSTEM_PROT |=> readData[13:0] == $past(systemProtFlags[13:0], 2))
    else $error("system protection flags lost");
  one_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_ONE |=> readData == $past(statusOneFlags, 2))
    else $error("status one flags lost");
  two_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_TWO |=> !readData[11]
    && readData[10:0] == $past(statusTwoFlags[10:0], 2)
    && readData[15:12] == $past(statusTwoFlags[15:12], 2))
    else $error("status two read wrong");
  three_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_STATUS_THREE |=> readData[12:0] == $past(statusThreeFlags[12:0], 2))
    else $error("status three flags lost");
  cfg_read_a: assert property (@(posedge mclk) disable iff (!rst_n)
    readReq && readIndex == sdsm_pkg::IDX_ACTIVE_CFG |=> readData[15:3] == 13'h0000
    && readData[2:0] == $past(activeCfgFlags[2:0], 2))
    else $error("configuration word read wrong");

  // state word shape: the bit groups must never combine into a pattern
  // that names no state, whatever the control machine hands over
  illegal_state_a: assert property (@(posedge mclk) disable iff (!rst_n)
    !$onehot(driveState) |=> driveStateWord == 16'h0000)
    else $error("illegal state code not shown as not ready");
  disabled_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveStateWord[6] |-> driveStateWord[5:0] == 6'h00)
    else $error("switch on disabled with low bits set");
  quick_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveStateWord[5] |-> !driveStateWord[6] && !driveStateWord[3]
    && driveStateWord[0])
    else $error("bit five set outside the powered states");
  fault_low_a: assert property (@(posedge mclk) disable iff (!rst_n)
    driveStateWord[3] |-> !driveStateWord[6] && !driveStateWord[5])
    else $error("fault pattern with stray bits");

endmodule // sdsm_monitor
`default_nettype wire

// ===== tb/sdsm_host.sv
// network host model that reads monitor parameters one at a time
`timescale 1ns/1ps
`default_nettype none
module sdsm_host (
  input wire logic mclk,
  output logic readReq,
  output logic [sdsm_pkg::IDX_W-1:0] readIndex,
  input wire logic readValid,
  input wire logic readHit,
  input wire logic [15:0] readData
);
  // idle bus at time zero
  initial begin
    readReq = 1'b0;
    readIndex = 10'h000;
  end
  // request held through the taking edge, answer sampled mid-cycle
  task automatic doRead(input logic [9:0] idx, output logic hit, output logic [15:0] data,
      output logic ok);
    ok = 1'b0;
    @(posedge mclk);
    readReq <= 1'b1;
    readIndex <= idx;
    @(posedge mclk);
    readReq <= 1'b0;
    readIndex <= ~idx; // released index carries junk so a stale index cannot pass
    for (int i = 0; i < 4 && !ok; i++) begin
      @(negedge mclk);
      ok = (readValid === 1'b1);
    end
    hit = readHit;
    data = readData;
  endtask
endmodule // sdsm_host
`default_nettype wire

// ===== tb/sdsm_monitor_bench.sv
// self-checking bench for the drive status monitor
`timescale 1ns/1ps
`default_nettype none
module sdsm_monitor_bench;
  logic mclk, rst_n, readReq, readValid, readHit, hit, ok;
  logic [9:0] readIndex;
  logic [15:0] readData, driveStateWord, data;
  sdsm_pkg::sdsm_state_t driveState;
  logic [15:0] flags [7];
  int bad_count, checks;
  int unsigned seed = 32'h0001_65bd;
  // model tables: flag word index and implemented bits, then state encodings
  logic [9:0] idxTab [7] = '{sdsm_pkg::IDX_EVENT_ACTION, sdsm_pkg::IDX_DRIVE_PROT,
      sdsm_pkg::IDX_SYSTEM_PROT, sdsm_pkg::IDX_STATUS_ONE, sdsm_pkg::IDX_STATUS_TWO,
      sdsm_pkg::IDX_STATUS_THREE, sdsm_pkg::IDX_ACTIVE_CFG};
  logic [15:0] maskTab [7] = '{16'h00ff, 16'h007f, 16'h3fff, 16'hffff, 16'hf7ff,
      16'h1fff, 16'h0007};
  logic [15:0] stExp [8] = '{16'h0000, 16'h0040, 16'h0021, 16'h0023, 16'h0027,
      16'h0007, 16'h000f, 16'h0008};
  sdsm_monitor dut (.mclk(mclk), .rst_n(rst_n), .driveState(driveState),
    .bridgeFlags(flags[0]), .driveProtFlags(flags[1]), .systemProtFlags(flags[2]),
    .statusOneFlags(flags[3]), .statusTwoFlags(flags[4]), .statusThreeFlags(flags[5]),
    .activeCfgFlags(flags[6]), .readReq(readReq), .readIndex(readIndex),
    .readValid(readValid), .readHit(readHit), .readData(readData),
    .driveStateWord(driveStateWord));
  sdsm_host host (.mclk(mclk), .readReq(readReq), .readIndex(readIndex),
    .readValid(readValid), .readHit(readHit), .readData(readData));
  // 20 MHz clock
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  function automatic int unsigned nextRand();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // a host read that must answer within a few cycles, hit flag and data compared
  task automatic rd(input logic [9:0] idx, input logic expHit, input logic [15:0] exp);
    host.doRead(idx, hit, data, ok);
    if (ok !== 1'b1) begin
      bad_count++;
      conclude();
    end
    chk("readHit", {15'h0, hit}, {15'h0, expHit});
    chk("readData", data, exp);
  endtask
  // main sequence: states, flag words, unmapped reads, reset in mid-run
  initial begin
    rst_n = 1'b0;
    driveState = sdsm_pkg::ST_NOT_READY;
    flags = '{default: 16'h0000};
    repeat (3) @(posedge mclk);
    chk("driveStateWord", driveStateWord, 16'h0000);
    rst_n <= 1'b1;
    for (int i = 0; i < 9; i++) begin
      @(posedge mclk);
      driveState <= sdsm_pkg::sdsm_state_t'(i < 8 ? 8'h01 << i : 8'h03);
      repeat (3) @(posedge mclk);
      chk("driveStateWord", driveStateWord, stExp[i % 8]);
      rd(sdsm_pkg::IDX_STATE_WORD, 1'b1, stExp[i % 8]);
    end
    for (int r = 0; r < 6; r++) begin
      @(posedge mclk);
      for (int k = 0; k < 7; k++) begin
        flags[k] <= 16'(nextRand());
      end
      repeat (2) @(posedge mclk);
      for (int k = 0; k < 7; k++) begin
        rd(idxTab[k], 1'b1, flags[k] & maskTab[k]);
      end
      rd(10'h3a0 | 10'(nextRand() & 32'h0000_001f), 1'b0, 16'h0000);
    end
    rd(10'h00b, 1'b0, 16'h0000);
    @(posedge mclk);
    rst_n <= 1'b0;
    @(negedge mclk);
    chk("driveStateWord", driveStateWord, 16'h0000);
    chk("readValid", {15'h0, readValid}, 16'h0000);
    @(posedge mclk);
    rst_n <= 1'b1;
    rd(sdsm_pkg::IDX_DRIVE_PROT, 1'b1, flags[1] & 16'h007f);
    conclude();
  end
endmodule // sdsm_monitor_bench
`default_nettype wire
